// [hdl/see_pkg.sv]
// shared constants for the serial eeprom emulation slave
package see_pkg;

  // ***************************************************************
  // memory side
  // ***************************************************************
  localparam int          ADDR_W        = 18;      // decoded address bits
  localparam int          ADDR_BYTES    = 3;       // address bytes on the wire
  localparam logic [1:0]  ADDR_LAST_IDX = 2'h2;    // index of last address byte

  // ***************************************************************
  // i2c addressing
  // ***************************************************************
  localparam logic [6:0]  I2C_MEM_DEV   = 7'h50;   // memory bus address
  localparam logic [6:0]  I2C_SENS_DEV  = 7'h51;   // sensor bus address
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;    // bits in a byte

  // ***************************************************************
  // spi opcodes
  // ***************************************************************
  localparam logic [7:0]  OP_WRITE      = 8'h02;   // memory write
  localparam logic [7:0]  OP_READ       = 8'h03;   // memory read
  localparam logic [7:0]  OP_SENSOR     = 8'h80;   // sensor read

  // ***************************************************************
  // sensor selectors
  // ***************************************************************
  localparam logic [7:0]  SEL_VCC       = 8'h01;   // supply voltage
  localparam logic [7:0]  SEL_TEMP_C    = 8'h02;   // temperature celsius
  localparam logic [7:0]  SEL_TEMP_F    = 8'h03;   // temperature fahrenheit
  localparam int          SENS_W        = 32;      // float word width

  // ***************************************************************
  // pin synchroniser: {wp, mosi, cs_n, sclk, sda, scl}
  // ***************************************************************
  localparam int          PIN_N         = 6;
  localparam logic [5:0]  PIN_RST       = 6'h2f;   // idle levels with mosi low, wp set

endpackage

// [hdl/see_slave.sv]
// serial eeprom emulation slave: i2c and spi front ends over one memory port
//
// Overview of operation
// R1: nack memory address while write busy
// R2: address counter; current read returns, increments
// R3: master ends reads with nack, stop
// R4: random read: write address, restart read
// R5: sequential read advances counter per byte
// R6: sensor read at 0x51 with selector byte
// R7: selectors 1,2,3 return four-byte floats
// R8: latest sensor values latched for instant reads
// R9: spi clock idles high, capture rising
// R10: spi writes only while write protect low
// R11: select low per operation, high between
// R12: first spi byte is opcode
// R13: only low 18 address bits decoded
// R14: host holds protect low before select
// R15: host waits after select before clocking
// R16: host pauses after address before data
// R17: spi data streams, counter advances, immediate commit
// R18: spi sensor read: 0x80 then selector
// R19: memory answers at i2c address 0x50
// R20: i2c write: address, location, data bytes
// R21: protected writes discarded, transaction completes
`timescale 1ns/1ps
`default_nettype none

module see_slave #(
  parameter int                  AW = see_pkg::ADDR_W
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  // i2c pins, open drain data
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  // spi pins
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              mosi_i,
  input  wire logic              wp_i,
  output logic                   miso_o,
  output logic                   miso_oe_n_o,
  // memory port, same clock
  output logic      [AW-1:0]     mem_addr_o,
  output logic      [7:0]        mem_wdata_o,
  output logic                   mem_we_o,
  input  wire logic [7:0]        mem_rdata_i,
  input  wire logic              mem_busy_i,
  // sensor samples, same clock
  input  wire logic [31:0]       sens_vcc_i,
  input  wire logic [31:0]       sens_temp_c_i,
  input  wire logic [31:0]       sens_temp_f_i,
  input  wire logic              sens_upd_i
);

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [5:0] {
    I_IDLE = 6'h01,   // not addressed
    I_DEV  = 6'h02,   // receiving bus address
    I_ACK  = 6'h04,   // ack bit clock
    I_RX   = 6'h08,   // receiving write bytes
    I_TX   = 6'h10,   // sending read bytes
    I_MACK = 6'h20    // sampling master ack
  } see_i2c_state_type;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,   // select high
    S_OP   = 6'h02,   // opcode byte
    S_ADDR = 6'h04,   // address bytes
    S_SEL  = 6'h08,   // sensor selector
    S_WR   = 6'h10,   // write data stream
    S_RD   = 6'h20    // read data stream, also unknown opcodes
  } see_spi_state_type;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [see_pkg::PIN_N-1:0] pins;   // synchronised pin levels

  see_sync #(
    .N       (see_pkg::PIN_N),
    .RST_VAL (see_pkg::PIN_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .async_i    ({wp_i, mosi_i, cs_n_i, sclk_i, sda_i, scl_i}),
    .sync_o     (pins)
  );

  logic scl_s, sda_s, sclk_s, cs_n_s, mosi_s, wp_s;
  assign {wp_s, mosi_s, cs_n_s, sclk_s, sda_s, scl_s} = pins;

  // ***************************************************************
  // state
  // ***************************************************************
  logic                   scl_q, sda_q, sclk_q;      // previous levels
  see_i2c_state_type      i_st, next_i_st;
  logic [3:0]             i_bit, next_i_bit;         // bit count
  logic [7:0]             i_sh, next_i_sh;           // shift register
  logic                   i_rd, next_i_rd;           // read direction
  logic                   i_sens, next_i_sens;       // sensor address hit
  logic [1:0]             i_cnt, next_i_cnt;         // write byte index, saturates
  logic [7:0]             i_sel, next_i_sel;         // sensor selector
  logic [1:0]             i_sidx, next_i_sidx;       // sensor byte index
  see_spi_state_type      s_st, next_s_st;
  logic [2:0]             s_bit, next_s_bit;
  logic [7:0]             s_rx, next_s_rx;
  logic [7:0]             s_tx, next_s_tx;
  logic                   s_wr, next_s_wr;           // write opcode seen
  logic                   s_sens, next_s_sens;       // sensor selector received
  logic [1:0]             s_cnt, next_s_cnt;         // address byte index
  logic                   s_pend, next_s_pend;       // load tx next cycle
  logic [7:0]             s_sel, next_s_sel;
  logic [1:0]             s_sidx, next_s_sidx;
  logic [AW-1:0]          next_addr;
  logic [7:0]             next_wdata;
  logic                   next_we;
  logic                   next_sda_oe_n, next_miso, next_miso_oe_n;
  logic [3*see_pkg::SENS_W-1:0] sens, next_sens;     // latched samples

  // sensor byte pick, msb first; unknown selector reads zero
  function automatic logic [7:0] sens_byte(input logic [7:0] sel,
                                           input logic [1:0] idx,
                                           input logic [3*see_pkg::SENS_W-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    // R7: selector decode
    unique case (sel)
      see_pkg::SEL_VCC:    w = v[31:0];
      see_pkg::SEL_TEMP_C: w = v[63:32];
      see_pkg::SEL_TEMP_F: w = v[95:64];
      default:             w = 32'h0000_0000;
    endcase
    return w[8'(31 - 8 * idx) -: 8];
  endfunction

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb begin
    logic [7:0] byte_in;   // byte completed this edge
    logic [7:0] ld;        // byte loaded for transmit
    byte_in        = 8'h00;
    ld             = 8'h00;
    next_i_st = i_st;  next_i_bit = i_bit;  next_i_sh = i_sh;  next_i_rd = i_rd;
    next_i_sens = i_sens;  next_i_cnt = i_cnt;  next_i_sel = i_sel;  next_i_sidx = i_sidx;
    next_s_st = s_st;  next_s_bit = s_bit;  next_s_rx = s_rx;  next_s_tx = s_tx;
    next_s_wr = s_wr;  next_s_sens = s_sens;  next_s_cnt = s_cnt;  next_s_pend = 1'b0;
    next_s_sel = s_sel;  next_s_sidx = s_sidx;
    next_sda_oe_n  = sda_oe_n_o;
    next_miso      = miso_o;
    next_miso_oe_n = miso_oe_n_o;
    next_wdata     = mem_wdata_o;
    next_we        = 1'b0;
    // R17: counter steps in the cycle after each commit
    next_addr      = mem_we_o ? mem_addr_o + 1'b1 : mem_addr_o;
    // R8: keep latest samples
    next_sens      = sens_upd_i ? {sens_temp_f_i, sens_temp_c_i, sens_vcc_i} : sens;

    // -------------------- i2c --------------------
    if (scl_s && !sda_q && sda_s) begin
      // stop: release and wait
      next_i_st     = I_IDLE;
      next_sda_oe_n = 1'b1;
    end else if (scl_s && sda_q && !sda_s) begin
      // start or repeated start
      next_i_st     = I_DEV;
      next_i_bit    = 4'h0;
      next_sda_oe_n = 1'b1;
    end else begin
      unique case (i_st)
        I_IDLE: ;
        I_DEV, I_RX: begin
          if (scl_s && !scl_q) begin
            next_i_sh  = {i_sh[6:0], sda_s};
            next_i_bit = i_bit + 4'h1;
          end else if (!scl_s && scl_q && i_bit == see_pkg::BITS_PER_BYTE) begin
            next_i_bit = 4'h0;
            next_i_st  = I_ACK;
            next_i_rd  = 1'b0;
            if (i_st == I_DEV) begin
              next_i_rd   = i_sh[0];
              next_i_cnt  = 2'h0;
              next_i_sens = (i_sh[7:1] == see_pkg::I2C_SENS_DEV);
              // R1: busy memory leaves address unanswered
              // R19: memory address match
              // R6: sensor address match
              if ((i_sh[7:1] == see_pkg::I2C_MEM_DEV && !mem_busy_i)
                  || i_sh[7:1] == see_pkg::I2C_SENS_DEV) begin
                next_sda_oe_n = 1'b0;
              end else begin
                next_i_st = I_IDLE;
              end
            end else begin
              next_sda_oe_n = 1'b0;
              if (i_sens) begin
                // R6: selector byte
                next_i_sel  = i_sh;
                next_i_sidx = 2'h0;
              end else if (i_cnt <= see_pkg::ADDR_LAST_IDX) begin
                // R4: location bytes; R13: low bits kept
                next_addr  = AW'({mem_addr_o, i_sh});
                next_i_cnt = i_cnt + 2'h1;
              end else begin
                // R20: data byte stored; R21: dropped when protected
                next_we    = !wp_s;
                next_wdata = i_sh;
              end
            end
          end
        end
        I_ACK: begin
          if (!scl_s && scl_q) begin
            next_sda_oe_n = 1'b1;
            next_i_st     = i_rd ? I_TX : I_RX;
            if (i_rd) begin
              // R2: current byte then advance; R5: per byte
              if (i_sens) begin
                ld          = sens_byte(i_sel, i_sidx, sens);
                next_i_sidx = i_sidx + 2'h1;
              end else begin
                ld        = mem_rdata_i;
                next_addr = mem_addr_o + 1'b1;
              end
              next_i_sh     = ld;
              next_sda_oe_n = ld[7];
            end
          end
        end
        I_TX: begin
          if (!scl_s && scl_q) begin
            next_i_sh  = {i_sh[6:0], 1'b1};
            next_i_bit = i_bit + 4'h1;
            if (i_bit == 4'h7) begin
              next_sda_oe_n = 1'b1;
              next_i_bit    = 4'h0;
              next_i_st     = I_MACK;
            end else begin
              next_sda_oe_n = i_sh[6];
            end
          end
        end
        I_MACK: begin
          // R3: nack ends the read, stop follows
          if (scl_s && !scl_q) begin
            next_i_st = sda_s ? I_IDLE : I_ACK;
          end
        end
        default: next_i_st = I_IDLE;
      endcase
    end

    // -------------------- spi --------------------
    if (cs_n_s) begin
      // R11: select high ends any operation
      next_s_st      = S_IDLE;
      next_miso_oe_n = 1'b1;
    end else begin
      if (s_st == S_IDLE) begin
        // R12: opcode first
        next_s_st      = S_OP;
        next_s_bit     = 3'h0;
        next_miso_oe_n = 1'b0;
      end
      // R9: capture on rising edge of an idle-high clock
      if (s_st != S_IDLE && sclk_s && !sclk_q) begin
        byte_in    = {s_rx[6:0], mosi_s};
        next_s_rx  = byte_in;
        next_s_bit = s_bit + 3'h1;
        next_s_tx  = {s_tx[6:0], 1'b1};
        next_miso  = s_tx[6];
        if (s_bit == 3'h7) begin
          unique case (s_st)
            S_OP: begin
              next_s_cnt  = 2'h0;
              next_s_wr   = (byte_in == see_pkg::OP_WRITE);
              next_s_sens = 1'b0;
              if (byte_in == see_pkg::OP_WRITE || byte_in == see_pkg::OP_READ) begin
                next_s_st = S_ADDR;
              end else if (byte_in == see_pkg::OP_SENSOR) begin
                // R18: selector follows
                next_s_st = S_SEL;
              end else begin
                // unknown opcode: idle stream of ones
                next_s_st = S_RD;
                next_s_tx = 8'hff;
              end
            end
            S_ADDR: begin
              // R13: 24 bits in, low bits kept
              next_addr  = AW'({mem_addr_o, byte_in});
              next_s_cnt = s_cnt + 2'h1;
              if (s_cnt == see_pkg::ADDR_LAST_IDX) begin
                next_s_st   = s_wr ? S_WR : S_RD;
                next_s_pend = !s_wr;
              end
            end
            S_SEL: begin
              next_s_sel  = byte_in;
              next_s_sidx = 2'h0;
              next_s_sens = 1'b1;
              next_s_st   = S_RD;
              next_s_pend = 1'b1;
            end
            S_WR: begin
              // R10: protect pin gates the commit; R17: immediate
              next_we    = !wp_s;
              next_wdata = byte_in;
            end
            S_RD: next_s_pend = s_wr || s_sens || s_cnt != 2'h0;
            default: next_s_st = S_IDLE;
          endcase
        end
      end
      if (s_pend) begin
        // R17: next byte ready before the following rising edge
        if (s_sens) begin
          ld          = sens_byte(s_sel, s_sidx, sens);
          next_s_sidx = s_sidx + 2'h1;
        end else begin
          ld        = mem_rdata_i;
          next_addr = mem_addr_o + 1'b1;
        end
        next_s_tx = ld;
        next_miso = ld[7];
      end
    end
  end

  // ***************************************************************
  // registers, frozen while clock enable is low
  // ***************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;  sda_q <= 1'b1;  sclk_q <= 1'b1;
      i_st <= I_IDLE;  i_bit <= 4'h0;  i_sh <= 8'h00;  i_rd <= 1'b0;
      i_sens <= 1'b0;  i_cnt <= 2'h0;  i_sel <= 8'h00;  i_sidx <= 2'h0;
      s_st <= S_IDLE;  s_bit <= 3'h0;  s_rx <= 8'h00;  s_tx <= 8'hff;
      s_wr <= 1'b0;  s_sens <= 1'b0;  s_cnt <= 2'h0;  s_pend <= 1'b0;
      s_sel <= 8'h00;  s_sidx <= 2'h0;  sens <= '0;
      sda_o <= 1'b0;  sda_oe_n_o <= 1'b1;  miso_o <= 1'b1;  miso_oe_n_o <= 1'b1;
      mem_addr_o <= '0;  mem_wdata_o <= 8'h00;  mem_we_o <= 1'b0;
    end else if (ce_i) begin
      scl_q <= scl_s;  sda_q <= sda_s;  sclk_q <= sclk_s;
      i_st <= next_i_st;  i_bit <= next_i_bit;  i_sh <= next_i_sh;  i_rd <= next_i_rd;
      i_sens <= next_i_sens;  i_cnt <= next_i_cnt;  i_sel <= next_i_sel;
      i_sidx <= next_i_sidx;
      s_st <= next_s_st;  s_bit <= next_s_bit;  s_rx <= next_s_rx;  s_tx <= next_s_tx;
      s_wr <= next_s_wr;  s_sens <= next_s_sens;  s_cnt <= next_s_cnt;
      s_pend <= next_s_pend;  s_sel <= next_s_sel;  s_sidx <= next_s_sidx;
      sens <= next_sens;
      sda_o <= 1'b0;
      sda_oe_n_o <= next_sda_oe_n;  miso_o <= next_miso;  miso_oe_n_o <= next_miso_oe_n;
      mem_addr_o <= next_addr;  mem_wdata_o <= next_wdata;  mem_we_o <= next_we;
    end
  end

endmodule

`default_nettype wire

// [hdl/see_sync.sv]
// two flip-flop synchroniser bank for the serial pins
`timescale 1ns/1ps
`default_nettype none

module see_sync #(
  parameter int               N       = 6,
  parameter logic [N-1:0]     RST_VAL = '0
) (
  input  wire logic           core_clk_i,
  input  wire logic           reset_i,
  input  wire logic           ce_i,
  input  wire logic [N-1:0]   async_i,
  output logic      [N-1:0]   sync_o
);

  // ***************************************************************
  // per-bit two stage chain
  // ***************************************************************
  logic [N-1:0] meta;   // first stage, read only by second stage

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // first stage only feeds second, never any logic
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          meta[g]   <= RST_VAL[g];
          sync_o[g] <= RST_VAL[g];
        end else if (ce_i) begin
          meta[g]   <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [tb/see_host.sv]
// host master model driving the i2c and spi pins
`timescale 1ns/1ps
`default_nettype none

module see_host (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  input  wire logic miso_i,
  output logic      scl_o,
  output logic      sda_rel_o,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  output logic      wp_o
);
  localparam int IH = 16;  // i2c half bit, cycles
  localparam int SH = 8;   // spi half bit, cycles

  // idle levels; spi clock idles high
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    wp_o = 1'b1;
  end

  // every pin change lands on a falling edge
  task automatic nw(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic set_wp(input logic v);
    wp_o = v;
  endtask

  // also serves as repeated start from a low clock
  task automatic i2c_start;
    sda_rel_o = 1'b1;
    nw(IH);
    scl_o = 1'b1;
    nw(IH);
    sda_rel_o = 1'b0;
    nw(IH);
    scl_o = 1'b0;
  endtask

  task automatic i2c_stop;
    nw(4);
    sda_rel_o = 1'b0;
    nw(IH);
    scl_o = 1'b1;
    nw(IH);
    sda_rel_o = 1'b1;
    nw(IH);
  endtask

  task automatic i2c_bit(input logic b, output logic r);
    nw(4);
    sda_rel_o = b;
    nw(IH);
    scl_o = 1'b1;
    nw(IH / 2);
    r = sda_i;
    nw(IH / 2);
    scl_o = 1'b0;
  endtask

  // last read byte answered by host nack
  task automatic i2c_byte(input logic [7:0] d, input logic a,
                          output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], q[i]);
    i2c_bit(a, k);
  endtask

  // mode 3, data set on fall
  task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = d[i];
      nw(SH);
      q[i] = miso_i;
      sclk_o = 1'b1;
      nw(SH);
    end
  endtask

  task automatic spi_frame(input logic [7:0] op, input int na, input logic [23:0] a,
                           input int nd, input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] q;
    rd = '0;
    nw(400);
    cs_n_o = 1'b0;
    nw(1350);
    spi_byte(op, q);
    for (int i = na - 1; i >= 0; i--) spi_byte(a[8*i +: 8], q);
    nw(2000);
    for (int i = nd - 1; i >= 0; i--) begin
      spi_byte(wd[8*i +: 8], q);
      rd[8*i +: 8] = q;
    end
    nw(SH);
    cs_n_o = 1'b1;
    nw(2 * SH);
  endtask
endmodule
`default_nettype wire

// [tb/see_slave_props.sv]
// port checker for the eeprom emulation slave
`timescale 1ns/1ps
`default_nettype none

module see_slave_props #(
  parameter int AW = 18
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic          scl_i,
  input  wire logic          sda_oe_n_o,
  input  wire logic          sclk_i,
  input  wire logic          cs_n_i,
  input  wire logic          wp_i,
  input  wire logic          miso_o,
  input  wire logic          miso_oe_n_o,
  input  wire logic [AW-1:0] mem_addr_o,
  input  wire logic          mem_we_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // ***************************************************************
  // sequences
  // ***************************************************************
  sequence s_spi_rise;
    !cs_n_i && $rose(sclk_i);
  endsequence
  sequence s_sda_move;
    $changed(sda_oe_n_o);
  endsequence
  sequence s_sda_pull;
    $fell(sda_oe_n_o);
  endsequence

  // ***************************************************************
  // properties
  // ***************************************************************
  property p_we_pulse;
    mem_we_o |=> !mem_we_o;
  endproperty
  property p_we_step;
    mem_we_o |=> mem_addr_o == AW'($past(mem_addr_o) + 1'b1);
  endproperty
  // synced protect level needs three cycles, eight is safe
  property p_wp_block;
    wp_i [*8] |-> !mem_we_o;
  endproperty
  property p_miso_idle;
    cs_n_i [*5] |-> miso_oe_n_o;
  endproperty
  property p_miso_drive;
    !cs_n_i [*5] |-> !miso_oe_n_o;
  endproperty
  // host samples on the rise, so data must not move there
  property p_miso_hold;
    s_spi_rise |-> $stable(miso_o) [*2];
  endproperty
  // moving sda under a high clock would fake start or stop
  property p_sda_edge;
    s_sda_move |-> !scl_i && !$past(scl_i, 2);
  endproperty
  property p_ack_hold;
    s_sda_pull |-> !sda_oe_n_o [*8];
  endproperty

  a_we_pulse:   assert property (p_we_pulse) else $error("write strobe too long");
  a_we_step:    assert property (p_we_step) else $error("counter not advanced");
  a_wp_block:   assert property (p_wp_block) else $error("write while protected");
  a_miso_idle:  assert property (p_miso_idle) else $error("miso driven unselected");
  a_miso_drive: assert property (p_miso_drive) else $error("miso floats selected");
  a_miso_hold:  assert property (p_miso_hold) else $error("miso moved at rise");
  a_sda_edge:   assert property (p_sda_edge) else $error("sda moved, clock high");
  a_ack_hold:   assert property (p_ack_hold) else $error("sda low too short");
endmodule

bind see_slave see_slave_props #(.AW(AW)) u_props (
  .core_clk_i  (core_clk_i),
  .reset_i     (reset_i),
  .scl_i       (scl_i),
  .sda_oe_n_o  (sda_oe_n_o),
  .sclk_i      (sclk_i),
  .cs_n_i      (cs_n_i),
  .wp_i        (wp_i),
  .miso_o      (miso_o),
  .miso_oe_n_o (miso_oe_n_o),
  .mem_addr_o  (mem_addr_o),
  .mem_we_o    (mem_we_o)
);
`default_nettype wire

// [tb/tb.sv]
// self-checking testbench for the eeprom emulation slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_checks++; \
    if ((gt) !== (ex)) begin \
      num_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb;
  // ***************************************************************
  // pins, memory, counters
  // ***************************************************************
  localparam logic [31:0] SV [1:3] = '{32'h40533333, 32'h41c80000, 32'h42a00000};
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  wire  logic                    scl, sda_rel, sclk, cs_n, mosi, wp;  // host pins
  wire  logic                    sda_w, miso_w;                     // resolved lines
  logic                          sda_d, sda_oe_n, miso, miso_oe_n, mem_we;
  logic [see_pkg::ADDR_W-1:0]    mem_addr;
  logic [7:0]                    mem_wdata;
  wire  logic [7:0]              mem_rdata;
  logic                          mem_busy = 1'b0;
  logic [31:0]                   s_v = SV[1];
  logic [31:0]                   s_c = SV[2];
  logic [31:0]                   s_f = SV[3];
  logic                          s_upd = 1'b0;
  logic [7:0]                    mem [0:262143];
  int                            num_errors = 0;
  int                            n_checks = 0;

  always #5 clk = ~clk;
  // pull-up on sda; a released miso shows the inverse
  assign sda_w = sda_rel & (sda_oe_n | sda_d);
  assign miso_w = miso_oe_n ? ~miso : miso;
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;

  function automatic logic [7:0] pat(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  initial for (int i = 0; i < 262144; i++) mem[i] = pat(18'(i));

  see_slave dut (
    .core_clk_i (clk), .reset_i (rst), .ce_i (1'b1),
    .scl_i (scl), .sda_i (sda_w), .sda_o (sda_d), .sda_oe_n_o (sda_oe_n),
    .sclk_i (sclk), .cs_n_i (cs_n), .mosi_i (mosi), .wp_i (wp),
    .miso_o (miso), .miso_oe_n_o (miso_oe_n),
    .mem_addr_o (mem_addr), .mem_wdata_o (mem_wdata), .mem_we_o (mem_we),
    .mem_rdata_i (mem_rdata), .mem_busy_i (mem_busy),
    .sens_vcc_i (s_v), .sens_temp_c_i (s_c), .sens_temp_f_i (s_f), .sens_upd_i (s_upd)
  );
  see_host host (
    .core_clk_i (clk), .sda_i (sda_w), .miso_i (miso_w), .scl_o (scl),
    .sda_rel_o (sda_rel), .sclk_o (sclk), .cs_n_o (cs_n), .mosi_o (mosi), .wp_o (wp)
  );

  // ***************************************************************
  // helpers and scenarios
  // ***************************************************************
  task automatic iw(input logic [7:0] d, input logic nk);
    logic [7:0] q;
    logic k;
    host.i2c_byte(d, 1'b1, q, k);
    `CHK("i2c ack", nk, k);
  endtask
  task automatic ir(input logic [7:0] e, input logic nk);
    logic [7:0] q;
    logic k;
    host.i2c_byte(8'hff, nk, q, k);
    `CHK("i2c data", e, q);
  endtask

  // start, memory address, location 0x10010
  task automatic i2c_loc;
    host.i2c_start;
    iw(8'ha0, 1'b0);
    iw(8'hfd, 1'b0);
    iw(8'h00, 1'b0);
    iw(8'h10, 1'b0);
  endtask
  task automatic t_i2c_mem;
    host.set_wp(1'b0);
    i2c_loc;
    iw(8'h11, 1'b0);
    iw(8'h22, 1'b0);
    host.i2c_stop;
    `CHK("i2c wr", 16'h1122, {mem[18'h10010], mem[18'h10011]});
    // random then sequential read
    i2c_loc;
    host.i2c_start;
    iw(8'ha1, 1'b0);
    ir(8'h11, 1'b0);
    ir(8'h22, 1'b0);
    ir(pat(18'h10012), 1'b1);
    host.i2c_stop;
    // current address read continues from counter
    host.i2c_start;
    iw(8'ha1, 1'b0);
    ir(pat(18'h10013), 1'b1);
    host.i2c_stop;
    host.set_wp(1'b1);
    i2c_loc;
    iw(8'h99, 1'b0);
    host.i2c_stop;
    `CHK("i2c wp", 8'h11, mem[18'h10010]);
  endtask
  task automatic t_i2c_busy;
    mem_busy = 1'b1;
    host.i2c_start;
    iw(8'ha0, 1'b1);
    host.i2c_stop;
    mem_busy = 1'b0;
    host.i2c_start;
    iw(8'ha4, 1'b1);
    host.i2c_stop;
    host.i2c_start;
    iw(8'ha0, 1'b0);
    host.i2c_stop;
  endtask
  // values latched by the pulse, not the live inputs
  task automatic t_i2c_sens;
    s_upd = 1'b1;
    @(negedge clk);
    s_upd = 1'b0;
    s_v = '0;
    s_c = '0;
    s_f = '0;
    for (int s = 1; s < 4; s++) begin
      host.i2c_start;
      iw(8'ha2, 1'b0);
      iw(8'(s), 1'b0);
      host.i2c_start;
      iw(8'ha3, 1'b0);
      for (int b = 3; b >= 0; b--) ir(SV[s][8*b +: 8], b == 0);
      host.i2c_stop;
    end
  endtask
  task automatic t_spi;
    logic [31:0] rd;
    host.set_wp(1'b0);
    host.spi_frame(8'h02, 3, 24'hfc1234, 3, 32'ha1b2c3, rd);
    `CHK("spi wr", 24'ha1b2c3, {mem[18'h1234], mem[18'h1235], mem[18'h1236]});
    host.set_wp(1'b1);
    host.spi_frame(8'h02, 3, 24'h001234, 2, 32'h5566, rd);
    `CHK("spi wp", 16'ha1b2, {mem[18'h1234], mem[18'h1235]});
    host.spi_frame(8'h03, 3, 24'hc01234, 4, '0, rd);
    `CHK("spi rd", {24'ha1b2c3, pat(18'h1237)}, rd);
    host.spi_frame(8'h55, 3, 24'h001234, 1, '0, rd);
    `CHK("spi bad op", 32'hff, rd);
    for (int s = 1; s < 5; s++) begin
      host.spi_frame(8'h80, 1, 24'(s), 4, '0, rd);
      `CHK("spi sensor", ((s < 4) ? SV[s] : 32'h0), rd);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard well above the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_i2c_mem;
    t_i2c_busy;
    t_i2c_sens;
    t_spi;
    report_and_stop;
  end
endmodule
`default_nettype wire
